// [hdl/fcs_pkg.sv]
// Constants, types and register map of the flash command host controller.
package fcs_pkg;
    localparam int CLK_MHZ  = 125;
    localparam int T_WE_NS  = 50;
    localparam int T_ACC_NS = 80;
    localparam int T_RP_NS  = 100;
    localparam int WE_CYC   = (T_WE_NS * CLK_MHZ + 999) / 1000;
    localparam int ACC_CYC  = (T_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int RP_CYC   = (T_RP_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNC_LEN = 3;
    localparam logic [7:0] WR_END = 8'(WE_CYC + 3);
    localparam logic [7:0] RD_END = 8'(ACC_CYC + SYNC_LEN);
    localparam logic [7:0] RP_END = 8'(RP_CYC);
    localparam logic [7:0] CMD_ARRAY    = 8'hff;
    localparam logic [7:0] CMD_IDENT    = 8'h90;
    localparam logic [7:0] CMD_STATUS   = 8'h70;
    localparam logic [7:0] CMD_CLEAR    = 8'h50;
    localparam logic [7:0] CMD_PROG     = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT = 8'h10;
    localparam logic [7:0] CMD_ERASE    = 8'h20;
    localparam logic [7:0] CMD_CONFIRM  = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND  = 8'hb0;
    localparam int SR_READY = 7;
    localparam int SR_SUSP  = 6;
    localparam int SR_VLOW  = 3;
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_ADDR  = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STAT  = 8'h0c;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam int CTRL_BYTE = 8;
    localparam int CTRL_BOOT = 9;
    localparam int CTRL_ALT  = 10;
    localparam int STAT_SR_LSB = 8;
    typedef enum logic [3:0] {
        OP_READ, OP_IDENT, OP_STATUS, OP_CLEAR, OP_PROG,
        OP_ERASE, OP_SUSP, OP_RESUME, OP_NULL, OP_RESET
    } fcs_op_t;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_W1   = 3'h1,
        S_W2   = 3'h3,
        S_POLL = 3'h2,
        S_RD   = 3'h6,
        S_RST  = 3'h4
    } fcs_st_t;
    typedef struct packed {
        logic rp_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fcs_ctl_t;
    localparam fcs_ctl_t CTL_RESET = 4'h7;
endpackage

// [hdl/fcs_host.sv]
// Host controller that sequences commands into a parallel flash through its pins.
// Function
// - Device starts in array read; host writes FFH to return there.
// - Program setup 40H or 10H, then address and data next cycle.
// - Boot block programs only with write-protect high or reset at high voltage.
// - A data cycle of all ones cancels a program setup.
// - Erase is 20H then D0H with an address in the block.
// - In suspend only array read, resume and status read are allowed.
//
// Local design decisions: the address map and strobed register access.
module fcs_host
    import fcs_pkg::*;
#(
    parameter int AW = 18,
    parameter int DW = 16
) (
    input  wire logic          I_CLK,
    input  wire logic          I_RSTN,
    input  wire logic [7:0]    I_ADDR,
    input  wire logic [31:0]   I_WDATA,
    input  wire logic          I_WR,
    input  wire logic          I_RD,
    output logic [31:0]        O_RDATA,
    output fcs_ctl_t           O_CTL,
    output logic [AW-1:0]      O_FA,
    output logic [DW-1:0]      O_DQ,
    output logic               O_DQ_OE_N,
    input  wire logic [DW-1:0] I_DQ,
    output logic               O_BYTE_N,
    output logic               O_WP,
    output logic               O_VPP_EN
);
    fcs_st_t         st_reg;
    fcs_op_t         op_reg;
    logic [7:0]      cnt_reg;
    logic            go_reg;
    logic            byte_reg;
    logic            boot_reg;
    logic            alt_reg;
    logic [31:0]     addr_reg;
    logic [DW-1:0]   wdata_reg;
    logic            refused_reg;
    logic            array_reg;
    logic            susp_reg;
    logic            erun_reg;
    logic [7:0]      sr_reg;
    logic [DW-1:0]   rdat_reg;
    logic [DW-1:0]   s1_reg;
    logic [DW-1:0]   s2_reg;
    logic [DW-1:0]   s3_reg;
    fcs_ctl_t        ctl_reg;
    logic [DW-1:0]   dq_reg;
    logic            dq_oe_n_reg;
    logic            vpp_reg;
    logic [31:0]     rdata_reg;
    fcs_op_t         new_op;
    logic            ctrl_wr;
    logic            accept;
    logic            wr_st;
    logic            rd_st;
    logic            w1_end;
    logic            rd_done;
    logic [7:0]      w1_cmd;
    logic [DW-1:0]   w2_data;
    fcs_st_t         after_w1;

    function automatic logic op_ok(fcs_op_t op, logic susp, logic erun, logic vlow);
        logic ok;
        ok = 1'b0;
        case (op)
            OP_RESET:  ok = 1'b1;
            OP_STATUS: ok = 1'b1;
            OP_SUSP:   ok = erun && !susp;
            OP_RESUME: ok = susp;
            OP_READ:   ok = !erun;
            OP_IDENT:  ok = !erun && !susp;
            OP_CLEAR:  ok = !erun && !susp;
            OP_PROG:   ok = !erun && !susp && !vlow;
            OP_ERASE:  ok = !erun && !susp && !vlow;
            OP_NULL:   ok = !erun && !susp && !vlow;
            default:   ok = 1'b0;
        endcase
        return ok;
    endfunction

    assign new_op  = fcs_op_t'(I_WDATA[3:0]);
    assign ctrl_wr = I_WR && (I_ADDR == REG_CTRL);
    // Mirrors the device's suspend, erase-running and low-voltage gating; boot-block and bad-supply refusals still reach the pins.
    assign accept  = ctrl_wr && st_reg == S_IDLE && !go_reg
                     && op_ok(new_op, susp_reg, erun_reg, sr_reg[SR_VLOW]);
    assign wr_st   = (st_reg == S_W1) || (st_reg == S_W2);
    assign rd_st   = (st_reg == S_RD) || (st_reg == S_POLL);
    assign w1_end  = (st_reg == S_W1) && (cnt_reg == WR_END);
    assign rd_done = rd_st && (cnt_reg == RD_END) && (s2_reg == s3_reg);

    always_comb begin
        case (op_reg)
            OP_READ:   w1_cmd = CMD_ARRAY;
            OP_IDENT:  w1_cmd = CMD_IDENT;
            OP_STATUS: w1_cmd = CMD_STATUS;
            OP_CLEAR:  w1_cmd = CMD_CLEAR;
            OP_PROG:   w1_cmd = alt_reg ? CMD_PROG_ALT : CMD_PROG;
            OP_NULL:   w1_cmd = CMD_PROG;
            OP_ERASE:  w1_cmd = CMD_ERASE;
            OP_SUSP:   w1_cmd = CMD_SUSPEND;
            OP_RESUME: w1_cmd = CMD_CONFIRM;
            default:   w1_cmd = CMD_STATUS;
        endcase
    end

    always_comb begin
        case (op_reg)
            OP_ERASE: w2_data = DW'(CMD_CONFIRM);
            OP_NULL:  w2_data = byte_reg ? DW'(8'hff) : '1;
            default:  w2_data = wdata_reg;
        endcase
    end

    always_comb begin
        case (op_reg)
            OP_PROG, OP_ERASE, OP_NULL:  after_w1 = S_W2;
            OP_READ, OP_IDENT, OP_STATUS: after_w1 = S_RD;
            OP_SUSP:                      after_w1 = S_POLL;
            default:                      after_w1 = S_IDLE;
        endcase
    end

    // Software side: configuration and the launch of one operation at a time.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            op_reg    <= OP_READ;
            go_reg    <= 1'b0;
            byte_reg  <= 1'b0;
            boot_reg  <= 1'b0;
            alt_reg   <= 1'b0;
            addr_reg  <= 32'h0;
            wdata_reg <= '0;
        end else begin
            go_reg <= accept;
            if (accept) begin
                op_reg   <= new_op;
                byte_reg <= I_WDATA[CTRL_BYTE];
                boot_reg <= I_WDATA[CTRL_BOOT];
                alt_reg  <= I_WDATA[CTRL_ALT];
            end
            if (I_WR && I_ADDR == REG_ADDR && st_reg == S_IDLE) begin
                addr_reg <= I_WDATA;
            end
            if (I_WR && I_ADDR == REG_WDATA && st_reg == S_IDLE) begin
                wdata_reg <= I_WDATA[DW-1:0];
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            refused_reg <= 1'b0;
        end else if (ctrl_wr && !accept) begin
            refused_reg <= 1'b1;
        end else if (I_WR && I_ADDR == REG_STAT) begin
            refused_reg <= 1'b0;
        end
    end

    // Sequencer: a reset pulse, or up to two bus writes, then a read, a poll, or nothing.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            st_reg  <= S_RST;
            cnt_reg <= 8'h00;
        end else begin
            case (st_reg)
                S_IDLE: begin
                    cnt_reg <= 8'h00;
                    if (go_reg) begin
                        if (op_reg == OP_RESET) begin
                            st_reg <= S_RST;
                        end else if ((op_reg == OP_READ && array_reg)
                                     || (op_reg == OP_STATUS && erun_reg)) begin
                            st_reg <= S_RD;
                        end else begin
                            st_reg <= S_W1;
                        end
                    end
                end
                S_W1, S_W2: begin
                    if (cnt_reg == WR_END) begin
                        cnt_reg <= 8'h00;
                        // Erase goes back to idle at once so that a suspend can still reach it.
                        st_reg  <= (st_reg == S_W1) ? after_w1
                                   : (op_reg == OP_ERASE) ? S_IDLE : S_POLL;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
                S_RD, S_POLL: begin
                    if (cnt_reg != RD_END) begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end else if (s2_reg == s3_reg) begin
                        cnt_reg <= 8'h00;
                        // Busy polls loop with output enable toggled so status refreshes.
                        if (st_reg == S_RD || s3_reg[SR_READY]) begin
                            st_reg <= S_IDLE;
                        end
                    end
                end
                S_RST: begin
                    if (cnt_reg == RP_END) begin
                        cnt_reg <= 8'h00;
                        st_reg  <= S_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
                default: begin
                    st_reg  <= S_IDLE;
                    cnt_reg <= 8'h00;
                end
            endcase
        end
    end

    // Host view of the device mode and its last status.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            array_reg <= 1'b1;
            susp_reg  <= 1'b0;
            erun_reg  <= 1'b0;
            sr_reg    <= 8'h80;
            rdat_reg  <= '0;
        end else if (st_reg == S_RST) begin
            array_reg <= 1'b1;
            susp_reg  <= 1'b0;
            erun_reg  <= 1'b0;
            sr_reg    <= 8'h80;
        end else begin
            if (w1_end) begin
                array_reg <= (op_reg == OP_READ);
                if (op_reg == OP_CLEAR) begin
                    sr_reg[5:3] <= 3'h0;
                end
                if (op_reg == OP_RESUME) begin
                    susp_reg <= 1'b0;
                    erun_reg <= 1'b1;
                end
            end
            if (st_reg == S_W2 && cnt_reg == WR_END && op_reg == OP_ERASE) begin
                erun_reg <= 1'b1;
            end
            if (rd_done) begin
                rdat_reg <= s3_reg;
                if (st_reg == S_POLL || op_reg == OP_STATUS) begin
                    sr_reg <= s3_reg[7:0];
                    if (s3_reg[SR_READY]) begin
                        erun_reg <= 1'b0;
                        if (op_reg == OP_SUSP) begin
                            susp_reg <= s3_reg[SR_SUSP];
                        end
                    end
                end
            end
        end
    end

    // Three-stage capture of the data pins; a value counts once stages two and three agree.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= I_DQ;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Pin timing. Write enable is kept inside chip enable on both edges for margin.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctl_reg     <= CTL_RESET;
            dq_reg      <= '0;
            dq_oe_n_reg <= 1'b1;
            vpp_reg     <= 1'b0;
        end else begin
            ctl_reg.rp_n <= (st_reg != S_RST);
            ctl_reg.ce_n <= !((wr_st && cnt_reg != 8'h00 && cnt_reg != WR_END)
                              || (rd_st && cnt_reg != 8'h00));
            ctl_reg.we_n <= !(wr_st && cnt_reg >= 8'h02 && cnt_reg <= WR_END - 8'h02);
            ctl_reg.oe_n <= !(rd_st && cnt_reg != 8'h00);
            dq_reg       <= (st_reg == S_W2) ? w2_data : DW'(w1_cmd);
            dq_oe_n_reg  <= !wr_st;
            vpp_reg      <= (st_reg == S_W2) || (st_reg == S_POLL) || erun_reg;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rdata_reg <= 32'h0;
        end else if (I_RD) begin
            case (I_ADDR)
                REG_CTRL:  rdata_reg <= {21'h0, alt_reg, boot_reg, byte_reg, 4'h0, op_reg};
                REG_ADDR:  rdata_reg <= addr_reg;
                REG_WDATA: rdata_reg <= 32'(wdata_reg);
                REG_STAT:  rdata_reg <= {16'h0, sr_reg, 3'h0, erun_reg, array_reg,
                                         susp_reg, refused_reg, st_reg != S_IDLE || go_reg};
                REG_RDATA: rdata_reg <= 32'(rdat_reg);
                default:   rdata_reg <= 32'h0;
            endcase
        end else begin
            rdata_reg <= 32'h0;
        end
    end

    assign O_RDATA   = rdata_reg;
    assign O_CTL     = ctl_reg;
    // Erase takes its block from the upper address bits of this same bus.
    assign O_FA      = addr_reg[AW-1:0];
    assign O_DQ      = dq_reg;
    assign O_DQ_OE_N = dq_oe_n_reg;
    assign O_BYTE_N  = !byte_reg;
    assign O_WP      = boot_reg;
    assign O_VPP_EN  = vpp_reg;

    logic [7:0] we_low_cnt;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            we_low_cnt <= 8'h00;
        end else begin
            we_low_cnt <= ctl_reg.we_n ? 8'h00 : we_low_cnt + 8'h01;
        end
    end

    a_we_oe_excl: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        !(!O_CTL.we_n && !O_CTL.oe_n)) else $error("write and output enable both low");
    a_we_width: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        $rose(O_CTL.we_n) |-> we_low_cnt == 8'(WE_CYC)) else $error("write pulse width wrong");
    a_prog_follow: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        w1_end && op_reg == OP_PROG |=> st_reg == S_W2) else $error("program data cycle missing");
    a_null_data: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        st_reg == S_W2 && op_reg == OP_NULL && cnt_reg == 8'h03 |->
        O_DQ == (byte_reg ? DW'(8'hff) : {DW{1'b1}})) else $error("null write value wrong");
    a_erase_confirm: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        st_reg == S_W2 && op_reg == OP_ERASE && !O_CTL.we_n |-> O_DQ[7:0] == CMD_CONFIRM)
        else $error("erase confirm code wrong");
    a_vlow_refuse: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        ctrl_wr && st_reg == S_IDLE && sr_reg[SR_VLOW]
        && (new_op == OP_PROG || new_op == OP_ERASE) |=> !go_reg && refused_reg)
        else $error("program accepted with voltage flag set");
    a_susp_only: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        susp_reg && go_reg |-> op_reg inside {OP_READ, OP_RESUME, OP_STATUS, OP_RESET})
        else $error("illegal command in suspend");
    a_reset_array: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        st_reg == S_RST && cnt_reg == RP_END |=> array_reg && !O_CTL.rp_n ##1 O_CTL.rp_n)
        else $error("reset did not restore array mode");
    a_poll_ready: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        rd_done && st_reg == S_POLL && !s3_reg[SR_READY] |=> st_reg == S_POLL)
        else $error("poll ended while busy");
endmodule

// [tb/fcs_flash_model.sv]
// Behavioural model of the parallel flash that the host controller drives.
module fcs_flash_model
    import fcs_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value.
    parameter logic [7:0] DEV_CODE   = 8'h3c, // Arbitrary value.
    parameter int         PROG_CYC   = 40,
    parameter int         ERASE_CYC  = 600
) (
    input  wire logic        i_clk,
    input  wire fcs_ctl_t    i_ctl,
    input  wire logic [17:0] i_fa,
    input  wire logic [15:0] i_dq,
    input  wire logic        i_dq_oe_n,
    input  wire logic        i_byte_n,
    input  wire logic        i_wp,
    input  wire logic        i_vpp_en,
    input  wire logic        i_vpp_bad,
    input  wire logic        i_fail,
    output logic [15:0]      o_dq
);
    typedef enum logic [2:0] {M_ARR, M_ID, M_SR, M_PSET, M_ESET, M_PROG, M_ERASE} fcs_mode_t;
    fcs_mode_t   mode_reg;
    logic [7:0]  sr_reg;
    logic [15:0] mem_reg [logic [17:0]];
    logic [17:0] tgt_reg;
    logic [15:0] val_reg;
    logic [15:0] last_reg = 16'h0;
    logic        we_reg;
    logic        susp_reg;
    logic        ok;
    logic [15:0] rv;
    int          cnt_reg;
    function automatic logic [4:0] blk(input logic [17:0] a, input logic b);
        return b ? a[16:12] : a[17:13];
    endfunction
    // Voltage is judged once, when the operation starts, and never while it runs.
    assign ok = !sr_reg[3] && i_vpp_en && !i_vpp_bad
        && (blk(i_fa, i_byte_n) != 5'h0 || i_wp);
    always @(posedge i_clk or negedge i_ctl.rp_n) begin
        if (!i_ctl.rp_n) begin
            mode_reg <= M_ARR;
            sr_reg   <= 8'h80;
            susp_reg <= 1'b0;
            cnt_reg  <= 0;
            we_reg   <= 1'b1;
        end else begin
            we_reg <= i_ctl.we_n;
            if (cnt_reg > 1 && !susp_reg) cnt_reg <= cnt_reg - 1;
            if (cnt_reg == 1 && !susp_reg) begin
                cnt_reg   <= 0;
                sr_reg[7] <= 1'b1;
                mode_reg  <= M_SR;
                if (i_fail) sr_reg[mode_reg == M_PROG ? 4 : 5] <= 1'b1;
                else if (mode_reg == M_PROG) mem_reg[tgt_reg] = val_reg;
                else foreach (mem_reg[k]) if (blk(k, i_byte_n) == blk(tgt_reg, i_byte_n))
                    mem_reg[k] = '1;
            end
            // Commands are latched on the closing edge of the write strobe.
            if (!we_reg && i_ctl.we_n && !i_ctl.ce_n) begin
                case (mode_reg)
                    M_PROG: ;
                    M_ERASE: if (i_dq[7:0] == CMD_SUSPEND) begin
                        susp_reg    <= 1'b1;
                        sr_reg[7:6] <= 2'b11;
                        mode_reg    <= M_SR;
                    end
                    M_PSET, M_ESET: begin
                        mode_reg <= M_SR;
                        tgt_reg  <= i_fa;
                        val_reg  <= i_dq;
                        if (mode_reg == M_PSET && (i_byte_n ? i_dq == 16'hffff : i_dq[7:0] == 8'hff))
                            ;
                        else if (mode_reg == M_ESET && i_dq[7:0] != CMD_CONFIRM)
                            sr_reg[5:4] <= 2'b11;
                        else if (ok) begin
                            mode_reg  <= (mode_reg == M_PSET) ? M_PROG : M_ERASE;
                            sr_reg[7] <= 1'b0;
                            cnt_reg   <= (mode_reg == M_PSET) ? PROG_CYC : ERASE_CYC;
                        end else if (!i_vpp_en || i_vpp_bad) sr_reg[3] <= 1'b1;
                        else if (!sr_reg[3]) sr_reg[mode_reg == M_PSET ? 4 : 5] <= 1'b1;
                    end
                    default: case (i_dq[7:0])
                        CMD_ARRAY: mode_reg <= M_ARR;
                        CMD_STATUS: mode_reg <= M_SR;
                        CMD_CONFIRM: if (susp_reg) begin
                            susp_reg    <= 1'b0;
                            sr_reg[7:6] <= 2'b00;
                            mode_reg    <= M_ERASE;
                        end
                        default: if (!susp_reg) begin
                            if (i_dq[7:0] == CMD_IDENT) mode_reg <= M_ID;
                            if (i_dq[7:0] == CMD_CLEAR) sr_reg[5:3] <= 3'h0;
                            if (i_dq[7:0] inside {CMD_PROG, CMD_PROG_ALT}) mode_reg <= M_PSET;
                            if (i_dq[7:0] == CMD_ERASE) mode_reg <= M_ESET;
                        end
                    endcase
                endcase
            end
        end
    end
    // An undriven bus flips every cycle so that a stale sample cannot pass.
    always @(posedge i_clk) last_reg <= o_dq;
    always @* begin
        if (mode_reg == M_ARR) rv = mem_reg.exists(i_fa) ? mem_reg[i_fa] : 16'hffff;
        else if (mode_reg == M_ID) rv = {8'h00, i_fa[0] ? DEV_CODE : MAKER_CODE};
        else rv = {8'h00, sr_reg};
        if (!i_dq_oe_n) o_dq = i_dq;
        else if (!i_ctl.ce_n && !i_ctl.oe_n && i_ctl.rp_n) o_dq = rv;
        else o_dq = ~last_reg;
    end
endmodule

// [tb/tb_fcs_host.sv]
// Self-checking bench for the flash command host controller.
module tb_fcs_host import fcs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MK = 8'h5a; // Arbitrary value.
    localparam logic [7:0] DV = 8'h3c; // Arbitrary value.
    logic        I_CLK = 1'b0, I_RSTN = 1'b0, I_WR = 1'b0, I_RD = 1'b0;
    logic        vbad = 1'b0, fail = 1'b0;
    logic [7:0]  I_ADDR = 8'h00;
    logic [31:0] I_WDATA = 32'h0, O_RDATA, s, r;
    fcs_ctl_t    O_CTL;
    logic [17:0] O_FA;
    logic [15:0] O_DQ, I_DQ;
    logic        O_DQ_OE_N, O_BYTE_N, O_WP, O_VPP_EN;
    int          n_errors = 0, checked = 0;
    always #4 I_CLK = ~I_CLK;
    fcs_host dut (
        .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
        .I_RD(I_RD), .O_RDATA(O_RDATA), .O_CTL(O_CTL), .O_FA(O_FA), .O_DQ(O_DQ),
        .O_DQ_OE_N(O_DQ_OE_N), .I_DQ(I_DQ), .O_BYTE_N(O_BYTE_N), .O_WP(O_WP),
        .O_VPP_EN(O_VPP_EN)
    );
    fcs_flash_model #(.MAKER_CODE(MK), .DEV_CODE(DV)) flash (
        .i_clk(I_CLK), .i_ctl(O_CTL), .i_fa(O_FA), .i_dq(O_DQ), .i_dq_oe_n(O_DQ_OE_N),
        .i_byte_n(O_BYTE_N), .i_wp(O_WP), .i_vpp_en(O_VPP_EN), .i_vpp_bad(vbad),
        .i_fail(fail), .o_dq(I_DQ)
    );
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= 1'b1;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_RD <= 1'b1;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        #1 d = O_RDATA;
    endtask
    // Polls the status word until every bit of the mask reads zero.
    task automatic wt(input logic [31:0] m);
        for (int i = 0; i < 2000; i++) begin
            rd(REG_STAT, s);
            if ((s & m) === 32'h0) return;
        end
        chk("wait", 32'h1, 32'h0);
        tally_and_finish();
    endtask
    task automatic go(input logic [31:0] c);
        wr(REG_CTRL, c);
        wt(32'h1);
    endtask
    task automatic put(input logic [17:0] a, input logic [31:0] d, input logic [31:0] c);
        wr(REG_ADDR, {14'h0, a});
        wr(REG_WDATA, d);
        go(c);
    endtask
    // Erase may run on after the launch, so status reads repeat until ready.
    task automatic fin();
        for (int i = 0; i < 500; i++) begin
            go(32'h2);
            if (s[15] === 1'b1 && s[4] === 1'b0) return;
        end
        chk("done", 32'h1, 32'h0);
        tally_and_finish();
    endtask
    task automatic arr(input logic [17:0] a, input logic [15:0] e);
        put(a, 32'h0, 32'h0);
        rd(REG_RDATA, r);
        chk("array", {16'h0, r[15:0]}, {16'h0, e});
    endtask
    task automatic sr(input logic [7:0] e);
        chk("status", {24'h0, s[15:8]}, {24'h0, e});
    endtask
    initial begin
        repeat (10) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        wt(32'h1);
        chk("array mode", {31'h0, s[3]}, 32'h1);
        put(18'h00000, 32'h0, 32'h1);
        rd(REG_RDATA, r);
        chk("maker", {24'h0, r[7:0]}, {24'h0, MK});
        put(18'h00001, 32'h0, 32'h1);
        rd(REG_RDATA, r);
        chk("device", {24'h0, r[7:0]}, {24'h0, DV});
        put(18'h02005, 32'h1234, 32'h4);
        fin();
        sr(8'h80);
        put(18'h03001, 32'h00aa, 32'h404);
        fin();
        arr(18'h02005, 16'h1234);
        arr(18'h03001, 16'h00aa);
        put(18'h02abc, 32'h0, 32'h5);
        fin();
        sr(8'h80);
        arr(18'h02005, 16'hffff);
        arr(18'h03001, 16'h00aa);
        put(18'h02005, 32'h5a5a, 32'h4);
        fin();
        put(18'h03000, 32'h0, 32'h5);
        go(32'h6);
        chk("suspended", {31'h0, s[2]}, 32'h1);
        chk("susp bits", {30'h0, s[15:14]}, 32'h3);
        arr(18'h02005, 16'h5a5a);
        go(32'h7);
        fin();
        chk("resumed", {31'h0, s[2]}, 32'h0);
        arr(18'h03001, 16'hffff);
        wr(REG_ADDR, 32'h02100);
        wr(REG_WDATA, 32'h0f0f);
        wr(REG_CTRL, 32'h4);
        wr(REG_CTRL, 32'h0);
        wt(32'h1);
        chk("refused", {31'h0, s[1]}, 32'h1);
        wr(REG_STAT, 32'h0);
        fin();
        chk("refused clear", {31'h0, s[1]}, 32'h0);
        arr(18'h02100, 16'h0f0f);
        fail <= 1'b1;
        put(18'h02200, 32'h1, 32'h4);
        fin();
        sr(8'h90);
        put(18'h04000, 32'h0, 32'h5);
        fin();
        sr(8'hb0);
        fail <= 1'b0;
        go(32'h3);
        fin();
        sr(8'h80);
        vbad <= 1'b1;
        put(18'h02300, 32'h1, 32'h4);
        fin();
        sr(8'h88);
        vbad <= 1'b0;
        wr(REG_CTRL, 32'h4);
        wt(32'h1);
        chk("vpp lock", {31'h0, s[1]}, 32'h1);
        go(32'h3);
        put(18'h00010, 32'h55, 32'h4);
        fin();
        sr(8'h90);
        go(32'h3);
        put(18'h00010, 32'h55, 32'h204);
        fin();
        sr(8'h80);
        arr(18'h00010, 16'h0055);
        put(18'h02400, 32'h1111, 32'h8);
        fin();
        sr(8'h80);
        arr(18'h02400, 16'hffff);
        put(18'h02600, 32'h0, 32'h108);
        fin();
        sr(8'h80);
        arr(18'h02600, 16'hffff);
        put(18'h05000, 32'h0, 32'h5);
        go(32'h9);
        chk("reset erase", {31'h0, s[4]}, 32'h0);
        chk("reset array", {31'h0, s[3]}, 32'h1);
        sr(8'h80);
        arr(18'h03001, 16'hffff);
        @(posedge I_CLK);
        I_RSTN <= 1'b0;
        repeat (3) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        wt(32'h1);
        chk("rst array", {31'h0, s[3]}, 32'h1);
        sr(8'h80);
        rd(REG_ADDR, r);
        chk("rst addr", r, 32'h0);
        rd(8'h20, r);
        chk("unmapped", r, 32'h0);
        tally_and_finish();
    end
endmodule
